/* File: rtl/iddl_map.svh */
`ifndef IDDL_MAP_SVH
`define IDDL_MAP_SVH

// ==========================================================
// Clock and link timing
// ==========================================================
`define IDDL_CLK_NS         25
`define IDDL_CK_NS          (2 * `IDDL_CLK_NS)
`define IDDL_RST_HOLD_NS    200000
`define IDDL_CKE_WAIT_NS    500000
`define IDDL_REF_NORM_NS    7800
`define IDDL_REF_HOT_NS     3900
`define IDDL_XPR_CK         16'h0078
`define IDDL_MOD_CK         16'h000C
`define IDDL_ZQINIT_CK      16'h0200
`define IDDL_RFC_CK         16'h0058

// ==========================================================
// Loop timing defaults, CK units of the fastest bin
// ==========================================================
`define IDDL_ACT_TO_PRE_CK  8'h1C
`define IDDL_ACT_TO_ACT_CK  8'h27
`define IDDL_ACT_TO_READ_CK 8'h0B
`define IDDL_ROW_ONES       4'hF
`define IDDL_LAST_BANK      3'h7

// ==========================================================
// Mode register values
// ==========================================================
`define IDDL_MR0_VAL        16'h0D70
`define IDDL_MR1_VAL        16'h0046
`define IDDL_MR2_VAL        16'h0418
`define IDDL_MR3_VAL        16'h0000
`define IDDL_MR2_SRT_BIT    7
`define IDDL_ZQ_LONG_BIT    10

// ==========================================================
// Software register map
// ==========================================================
`define IDDL_REG_CTRL       8'h00
`define IDDL_REG_STATUS     8'h04
`define IDDL_REG_TIMING     8'h08
`define IDDL_REG_PASSES     8'h0C
`define IDDL_CTRL_RUN_BIT   0
`define IDDL_CTRL_HOT_BIT   1
`define IDDL_CTRL_INIT_BIT  2
`define IDDL_ST_DONE_BIT    4
`define IDDL_ST_WARM_BIT    5
`define IDDL_ST_REF_BIT     6
`define IDDL_ST_MEAS_BIT    7

`endif

/* File: rtl/iddl_pkg.sv */
package iddl_pkg;

  typedef enum logic [3:0] {
    ST_RST_HOLD,
    ST_CKE_WAIT,
    ST_XPR,
    ST_MRS,
    ST_MRS_WAIT,
    ST_ZQ,
    ST_ZQ_WAIT,
    ST_IDLE,
    ST_REF,
    ST_REF_WAIT,
    ST_LOOP
  } iddl_state_type;

  typedef enum logic [2:0] {
    CMD_DES_Q,
    CMD_DES_T,
    CMD_ACT,
    CMD_PRE,
    CMD_MRS,
    CMD_REF,
    CMD_ZQCL
  } iddl_cmd_type;

endpackage

/* File: rtl/iddl_ref_timer.sv */
`timescale 1ns/100ps
`include "iddl_map.svh"
module iddl_ref_timer
  import iddl_pkg::*;
#(
  parameter int unsigned NORM_CYC = `IDDL_REF_NORM_NS / `IDDL_CLK_NS,
  parameter int unsigned HOT_CYC  = `IDDL_REF_HOT_NS / `IDDL_CLK_NS
)
(
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic enable_in,
  input  wire logic hot_in,
  input  wire logic ack_in,
  output logic      pending_out
);

  logic [15:0] cnt_ff;
  logic        pend_ff;
  logic [15:0] limit;
  logic        due;

  // ==========================================================
  // Interval counter
  // ==========================================================
  // Halved interval hot
  assign limit = hot_in ? 16'(HOT_CYC - 1) : 16'(NORM_CYC - 1);
  assign due   = enable_in && (cnt_ff >= limit);

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || !enable_in || due)
      cnt_ff <= 16'h0000;
    else
      cnt_ff <= cnt_ff + 16'h0001;
  end

  // Set beats a same-cycle acknowledge
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      pend_ff <= 1'b0;
    else if (due)
      pend_ff <= 1'b1;
    else if (ack_in)
      pend_ff <= 1'b0;
  end

  assign pending_out = pend_ff;

endmodule

/* File: rtl/iddl_loop_gen.sv */
`timescale 1ns/100ps
`include "iddl_map.svh"
module iddl_loop_gen
  import iddl_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic         clear_in,
  input  wire logic         step_in,
  input  wire logic [7:0]   act_to_act_in,
  input  wire logic [7:0]   act_to_pre_in,
  output iddl_cmd_type      cmd_out,
  output logic [2:0]        bank_out,
  output logic              row_ones_out,
  output logic              sub_end_out,
  output logic              pass_end_out
);

  logic [8:0] pos_ff;
  logic [2:0] bank_ff;
  logic       second;
  logic [8:0] local_pos;
  logic [8:0] gap_pos;

  // ==========================================================
  // Position within one sub-loop
  // ==========================================================
  assign second      = pos_ff >= {1'b0, act_to_act_in};
  assign local_pos   = second ? pos_ff - {1'b0, act_to_act_in} : pos_ff;
  assign gap_pos     = local_pos - 9'h001;
  assign sub_end_out = pos_ff == ({act_to_act_in, 1'b0} - 9'h001);
  assign pass_end_out = sub_end_out && (bank_ff == `IDDL_LAST_BANK);
  assign bank_out     = bank_ff;
  assign row_ones_out = second;

  always_comb
  begin
    if (local_pos == 9'h000)
      cmd_out = CMD_ACT;
    else if (local_pos == {1'b0, act_to_pre_in})
      cmd_out = CMD_PRE;
    else if (gap_pos[1])
      cmd_out = CMD_DES_T;
    else
      cmd_out = CMD_DES_Q;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || clear_in)
    begin
      pos_ff  <= 9'h000;
      bank_ff <= 3'h0;
    end
    else if (step_in)
    begin
      if (sub_end_out)
      begin
        pos_ff  <= 9'h000;
        bank_ff <= bank_ff + 3'h1;
      end
      else
        pos_ff <= pos_ff + 9'h001;
    end
  end

endmodule

/* File: rtl/iddl_ctrl.sv */
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "iddl_map.svh"
module iddl_ctrl
  import iddl_pkg::*;
#(
  parameter int unsigned RST_HOLD_TICKS = `IDDL_RST_HOLD_NS / `IDDL_CK_NS,
  parameter int unsigned CKE_WAIT_TICKS = `IDDL_CKE_WAIT_NS / `IDDL_CK_NS,
  parameter int unsigned ADDR_W         = 16,
  parameter int unsigned DQ_W           = 8
)
(
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic [31:0]            reg_rdata_out,
  output logic                   ck_out,
  output logic                   ck_n_out,
  output logic                   cke_out,
  output logic                   mem_reset_n_out,
  output logic                   cs_n_out,
  output logic                   ras_n_out,
  output logic                   cas_n_out,
  output logic                   we_n_out,
  output logic                   odt_out,
  output logic [2:0]             ba_out,
  output logic [ADDR_W-1:0]      addr_out,
  output logic                   dm_out,
  input  wire logic [DQ_W-1:0]   dq_in,
  output logic [DQ_W-1:0]        dq_out,
  output logic                   dq_oe_out,
  input  wire logic              dqs_in,
  output logic                   dqs_out,
  output logic                   dqs_oe_out,
  output logic                   meas_valid_out
);

  iddl_state_type    state_ff;
  iddl_state_type    nxt_state;
  logic [15:0]       wait_ff;
  logic [15:0]       nxt_wait;
  logic [1:0]        mr_idx_ff;
  logic [1:0]        nxt_mr_idx;
  logic              ck_ff;
  logic              tick;
  logic              run_ff;
  logic              hot_ff;
  logic              reinit_ff;
  logic [7:0]        act_to_pre_ff;
  logic [7:0]        act_to_act_ff;
  logic [15:0]       passes_ff;
  logic              warm_ff;
  logic              done_ff;
  logic [31:0]       rdata_ff;
  logic              cke_ff;
  logic              rst_n_ff;
  logic [3:0]        pins_ff;
  logic [2:0]        ba_ff;
  logic [ADDR_W-1:0] addr_ff;
  iddl_cmd_type      nxt_cmd;
  logic [2:0]        nxt_ba;
  logic [ADDR_W-1:0] nxt_addr;
  logic              gen_clear;
  logic              gen_step;
  logic              ref_ack;
  logic              reinit_take;
  iddl_cmd_type      gen_cmd;
  logic [2:0]        gen_bank;
  logic              gen_row_ones;
  logic              gen_sub_end;
  logic              gen_pass_end;
  logic              ref_pending;

  // ==========================================================
  // Pin encoding
  // ==========================================================
  // Chip select, row, column, write
  function automatic logic [3:0] cmd_pins(input iddl_cmd_type cmd);
    logic [3:0] p;
    p = 4'hF;
    unique case (cmd)
      CMD_ACT:   p = 4'h3;
      CMD_PRE:   p = 4'h2;
      CMD_DES_Q: p = 4'h8;
      CMD_DES_T: p = 4'hF;
      CMD_MRS:   p = 4'h0;
      CMD_REF:   p = 4'h1;
      CMD_ZQCL:  p = 4'h6;
    endcase
    return p;
  endfunction

  // Order MR2, MR3, MR1, MR0
  function automatic logic [15:0] mr_value(input logic [1:0] idx, input logic hot);
    logic [15:0] v;
    v = `IDDL_MR0_VAL;
    unique case (idx)
      // Extended temperature self refresh when hot
      2'h0: v = `IDDL_MR2_VAL | (16'(hot) << `IDDL_MR2_SRT_BIT);
      2'h1: v = `IDDL_MR3_VAL;
      2'h2: v = `IDDL_MR1_VAL;
      2'h3: v = `IDDL_MR0_VAL;
    endcase
    return v;
  endfunction

  // ==========================================================
  // Link clock
  // ==========================================================
  // Free-running clock
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      ck_ff <= 1'b0;
    else
      ck_ff <= ~ck_ff;
  end

  // Pins move on the falling edge, stable at the rising one
  assign tick = ck_ff;

  // ==========================================================
  // Sub-blocks
  // ==========================================================
  iddl_loop_gen i_iddl_loop_gen
  (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .clear_in      (tick && gen_clear),
    .step_in       (tick && gen_step),
    .act_to_act_in (act_to_act_ff),
    .act_to_pre_in (act_to_pre_ff),
    .cmd_out       (gen_cmd),
    .bank_out      (gen_bank),
    .row_ones_out  (gen_row_ones),
    .sub_end_out   (gen_sub_end),
    .pass_end_out  (gen_pass_end)
  );

  iddl_ref_timer i_iddl_ref_timer
  (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .enable_in   (done_ff),
    .hot_in      (hot_ff),
    .ack_in      (tick && ref_ack),
    .pending_out (ref_pending)
  );

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb
  begin
    nxt_state   = state_ff;
    nxt_wait    = (wait_ff == 16'h0000) ? 16'h0000 : wait_ff - 16'h0001;
    nxt_mr_idx  = mr_idx_ff;
    nxt_cmd     = CMD_DES_Q;
    nxt_ba      = 3'h0;
    nxt_addr    = '0;
    gen_clear   = 1'b0;
    gen_step    = 1'b0;
    ref_ack     = 1'b0;
    reinit_take = 1'b0;
    unique case (state_ff)
      // Reset, clock enable, mode set, calibration
      ST_RST_HOLD:
        if (wait_ff == 16'h0000)
        begin
          nxt_state = ST_CKE_WAIT;
          nxt_wait  = 16'(CKE_WAIT_TICKS - 1);
        end
      ST_CKE_WAIT:
        if (wait_ff == 16'h0000)
        begin
          nxt_state = ST_XPR;
          nxt_wait  = `IDDL_XPR_CK - 16'h0001;
        end
      ST_XPR:
        if (wait_ff == 16'h0000)
        begin
          nxt_state  = ST_MRS;
          nxt_mr_idx = 2'h0;
        end
      ST_MRS:
      begin
        nxt_cmd   = CMD_MRS;
        // Index order 0..3 maps to banks 2, 3, 1, 0
        nxt_ba    = {1'b0, ~mr_idx_ff[1], mr_idx_ff[1] ^ mr_idx_ff[0]};
        nxt_addr  = ADDR_W'(mr_value(mr_idx_ff, hot_ff));
        nxt_state = ST_MRS_WAIT;
        nxt_wait  = `IDDL_MOD_CK - 16'h0001;
      end
      ST_MRS_WAIT:
        if (wait_ff == 16'h0000)
        begin
          if (mr_idx_ff == 2'h3)
            nxt_state = ST_ZQ;
          else
          begin
            nxt_mr_idx = mr_idx_ff + 2'h1;
            nxt_state  = ST_MRS;
          end
        end
      ST_ZQ:
      begin
        nxt_cmd                    = CMD_ZQCL;
        nxt_addr[`IDDL_ZQ_LONG_BIT] = 1'b1;
        nxt_state                  = ST_ZQ_WAIT;
        nxt_wait                   = `IDDL_ZQINIT_CK - 16'h0001;
      end
      ST_ZQ_WAIT:
        if (wait_ff == 16'h0000)
          nxt_state = ST_IDLE;
      ST_IDLE:
        if (reinit_ff)
        begin
          reinit_take = 1'b1;
          nxt_mr_idx  = 2'h0;
          nxt_state   = ST_MRS;
        end
        else if (ref_pending)
          nxt_state = ST_REF;
        else if (run_ff)
        begin
          gen_clear = 1'b1;
          nxt_state = ST_LOOP;
        end
      ST_REF:
      begin
        nxt_cmd   = CMD_REF;
        ref_ack   = 1'b1;
        nxt_state = ST_REF_WAIT;
        nxt_wait  = `IDDL_RFC_CK - 16'h0001;
      end
      ST_REF_WAIT:
        if (wait_ff == 16'h0000)
          nxt_state = ST_IDLE;
      ST_LOOP:
      begin
        nxt_cmd   = gen_cmd;
        nxt_ba    = gen_bank;
        nxt_addr[6:3] = gen_row_ones ? `IDDL_ROW_ONES : 4'h0;
        gen_step  = 1'b1;
        // Leave only on a boundary where the bank is closed
        if (gen_sub_end && !run_ff)
          nxt_state = ST_IDLE;
        else if (gen_pass_end && ref_pending)
          nxt_state = ST_REF;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      state_ff  <= ST_RST_HOLD;
      wait_ff   <= 16'(RST_HOLD_TICKS - 1);
      mr_idx_ff <= 2'h0;
    end
    else if (tick)
    begin
      state_ff  <= nxt_state;
      wait_ff   <= nxt_wait;
      mr_idx_ff <= nxt_mr_idx;
    end
  end

  // ==========================================================
  // Command pins
  // ==========================================================
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      pins_ff  <= 4'hF;
      ba_ff    <= 3'h0;
      addr_ff  <= '0;
      cke_ff   <= 1'b0;
      rst_n_ff <= 1'b0;
    end
    else if (tick)
    begin
      pins_ff  <= cmd_pins(nxt_cmd);
      ba_ff    <= nxt_ba;
      addr_ff  <= nxt_addr;
      // Clock enable high after power-up wait
      cke_ff   <= (nxt_state != ST_RST_HOLD) && (nxt_state != ST_CKE_WAIT);
      rst_n_ff <= nxt_state != ST_RST_HOLD;
    end
  end

  assign ck_out          = ck_ff;
  assign ck_n_out        = ~ck_ff;
  assign cke_out         = cke_ff;
  assign mem_reset_n_out = rst_n_ff;
  assign cs_n_out        = pins_ff[3];
  assign ras_n_out       = pins_ff[2];
  assign cas_n_out       = pins_ff[1];
  assign we_n_out        = pins_ff[0];
  assign ba_out          = ba_ff;
  assign addr_out        = addr_ff;
  assign odt_out         = 1'b0;
  // Data and strobes released, mask low
  assign dm_out          = 1'b0;
  assign dq_out          = '0;
  assign dq_oe_out       = 1'b0;
  assign dqs_out         = 1'b0;
  assign dqs_oe_out      = 1'b0;

  // ==========================================================
  // Progress tracking
  // ==========================================================
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      done_ff <= 1'b0;
    else if (tick && (state_ff == ST_ZQ_WAIT) && (nxt_state == ST_IDLE))
      done_ff <= 1'b1;
  end

  // Warm after one full pass
  // Kept across refresh breaks, else a pass never stays warm
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      warm_ff   <= 1'b0;
      passes_ff <= 16'h0000;
    end
    else if (!run_ff)
    begin
      warm_ff   <= 1'b0;
      passes_ff <= 16'h0000;
    end
    else if (tick && (state_ff == ST_LOOP) && gen_pass_end)
    begin
      warm_ff   <= 1'b1;
      passes_ff <= passes_ff + 16'h0001;
    end
  end

  assign meas_valid_out = warm_ff && (state_ff == ST_LOOP);

  // ==========================================================
  // Software registers
  // ==========================================================
  // Bin counts as reset defaults
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      run_ff        <= 1'b0;
      hot_ff        <= 1'b0;
      act_to_pre_ff <= `IDDL_ACT_TO_PRE_CK;
      act_to_act_ff <= `IDDL_ACT_TO_ACT_CK;
    end
    else if (reg_wr_in && (reg_addr_in == `IDDL_REG_CTRL))
    begin
      run_ff <= reg_wdata_in[`IDDL_CTRL_RUN_BIT];
      hot_ff <= reg_wdata_in[`IDDL_CTRL_HOT_BIT];
    end
    else if (reg_wr_in && (reg_addr_in == `IDDL_REG_TIMING))
    begin
      act_to_pre_ff <= reg_wdata_in[7:0];
      act_to_act_ff <= reg_wdata_in[15:8];
    end
  end

  // Request wins over a same-cycle take
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      reinit_ff <= 1'b0;
    else if (reg_wr_in && (reg_addr_in == `IDDL_REG_CTRL)
             && reg_wdata_in[`IDDL_CTRL_INIT_BIT])
      reinit_ff <= 1'b1;
    else if (tick && reinit_take)
      reinit_ff <= 1'b0;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rdata_ff <= 32'h00000000;
    else if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        `IDDL_REG_CTRL:
          rdata_ff <= {29'h0, reinit_ff, hot_ff, run_ff};
        `IDDL_REG_STATUS:
          rdata_ff <= {24'h0, meas_valid_out, ref_pending, warm_ff, done_ff,
                       4'(state_ff)};
        `IDDL_REG_TIMING:
          rdata_ff <= {16'h0, act_to_act_ff, act_to_pre_ff};
        `IDDL_REG_PASSES:
          rdata_ff <= {16'h0, passes_ff};
        default:
          rdata_ff <= 32'h00000000;
      endcase
    end
    else
      rdata_ff <= 32'h00000000;
  end

  assign reg_rdata_out = rdata_ff;

endmodule

/* File: dv/iddl_ctrl_assertions.sv */
`timescale 1ns/100ps
module iddl_chk
  import iddl_pkg::*;
#(
  parameter int unsigned ADDR_W = 16
)
(
  input wire logic              clk_in,
  input wire logic              resetn_in,
  input wire logic              reg_rd_in,
  input wire logic [31:0]       reg_rdata_out,
  input wire logic              ck_out,
  input wire logic              ck_n_out,
  input wire logic              cke_out,
  input wire logic              mem_reset_n_out,
  input wire logic              cs_n_out,
  input wire logic              ras_n_out,
  input wire logic              cas_n_out,
  input wire logic              we_n_out,
  input wire logic              odt_out,
  input wire logic [2:0]        ba_out,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic              dm_out,
  input wire logic              dq_oe_out,
  input wire logic              dqs_oe_out
);
  logic [3:0] cmd;
  logic       act;
  logic       ones;
  assign cmd  = {cs_n_out, ras_n_out, cas_n_out, we_n_out};
  assign act  = (cmd == 4'h3);
  assign ones = (addr_out[6:3] == 4'hF);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================================
  // Memory pins
  // ==========================================================
  a_pins_rest: assert property (
    !odt_out && !dm_out && !dq_oe_out && !dqs_oe_out) else $error("pins not at rest");
  a_ck_toggle: assert property (
    $past(resetn_in) |-> ck_out != $past(ck_out) && ck_n_out == !ck_out)
    else $error("memory clock stalled");
  a_cke_order: assert property (
    !mem_reset_n_out |-> !cke_out) else $error("clock enable high in reset");
  a_cmd_fall: assert property (
    $past(resetn_in) && cmd != $past(cmd) |-> $fell(ck_out)) else $error("command off edge");
  a_cmd_legal: assert property (
    cmd inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8, 4'hF}) else $error("bad command code");
  // ==========================================================
  // Loop pattern and register read data
  // ==========================================================
  a_act_pre: assert property (
    $fell(ck_out) && act |-> ##56 cmd == 4'h2) else $error("precharge late or early");
  a_act_fill: assert property (
    $fell(ck_out) && act |-> ##2 cmd == 4'h8 ##2 cmd == 4'h8 ##2 cmd == 4'hF ##2 cmd == 4'hF)
    else $error("deselect fill wrong");
  a_second_act: assert property (
    $fell(ck_out) && act && addr_out[6:3] == 4'h0 |-> ##78 act && ones
    && ba_out == $past(ba_out, 78) && addr_out[ADDR_W-1:7] == '0 && addr_out[2:0] == 3'h0)
    else $error("second activate wrong");
  a_bank_step: assert property (
    $fell(ck_out) && act && ones |-> ##78 !act
    || (ba_out == 3'($past(ba_out, 78) + 3'h1) && addr_out[6:3] == 4'h0))
    else $error("bank step wrong");
  a_rdata_zero: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0) else $error("read data outside slot");
endmodule

bind iddl_ctrl iddl_chk #(.ADDR_W(ADDR_W)) i_iddl_chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ck_out(ck_out), .ck_n_out(ck_n_out),
  .cke_out(cke_out), .mem_reset_n_out(mem_reset_n_out), .cs_n_out(cs_n_out),
  .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .we_n_out(we_n_out), .odt_out(odt_out),
  .ba_out(ba_out), .addr_out(addr_out), .dm_out(dm_out), .dq_oe_out(dq_oe_out),
  .dqs_oe_out(dqs_oe_out));

/* File: dv/iddl_mem_model.sv */
`timescale 1ns/100ps
module iddl_mem_model
(
  input  wire logic        ck_in,
  input  wire logic        cke_in,
  input  wire logic        reset_n_in,
  input  wire logic [3:0]  cmd_in,
  input  wire logic [2:0]  ba_in,
  input  wire logic [15:0] addr_in,
  output logic [7:0]       dq_out = 8'hA5,
  output logic             dqs_out = 1'b0,
  output logic [3:0][15:0] mr_out = '0,
  output logic [15:0]      act_cnt_out = 16'h0,
  output logic [7:0]       ref_cnt_out = 8'h0,
  output logic [15:0]      ref_gap_out = 16'h0,
  output logic             order_err_out = 1'b0
);
  logic [15:0] ck_cnt   = 16'h0;
  logic [15:0] last_ref = 16'h0;
  logic        zq_seen  = 1'b0;
  always_ff @(posedge ck_in)
  begin
    ck_cnt <= ck_cnt + 16'h1;
    dq_out  <= ~dq_out;
    dqs_out <= ~dqs_out;
    if (!reset_n_in)
      zq_seen <= 1'b0;
    else
      case (cmd_in)
        4'h0: mr_out[ba_in[1:0]] <= addr_in;
        4'h6: zq_seen <= 1'b1;
        4'h1:
        begin
          ref_gap_out <= ck_cnt - last_ref;
          last_ref    <= ck_cnt;
          ref_cnt_out <= ref_cnt_out + 8'h1;
        end
        4'h3:
        begin
          act_cnt_out <= act_cnt_out + 16'h1;
          if (!zq_seen || !cke_in)
            order_err_out <= 1'b1;
        end
        default: ;
      endcase
  end
endmodule

/* File: dv/tb_iddl_ctrl.sv */
`timescale 1ns/100ps
`include "iddl_map.svh"
module tb_iddl_ctrl;
  import iddl_pkg::*;
  logic             clk_in = 1'b0;
  logic             resetn_in = 1'b0;
  logic [7:0]       reg_addr_in = 8'h00;
  logic [31:0]      reg_wdata_in = 32'h0;
  logic             reg_wr_in = 1'b0;
  logic             reg_rd_in = 1'b0;
  logic [31:0]      reg_rdata_out;
  logic [31:0]      d;
  logic             ck, ck_n, cke, mrst_n, cs_n, ras_n, cas_n, we_n, odt, dm;
  logic             dq_oe, dqs_in, dqs_o, dqs_oe, meas;
  logic [2:0]       ba;
  logic [15:0]      addr;
  logic [7:0]       dq_in;
  logic [7:0]       dq_o;
  logic [3:0][15:0] mr;
  logic [15:0]      act_cnt;
  logic [7:0]       ref_cnt;
  logic [15:0]      ref_gap;
  logic             order_err;
  logic [15:0]      act_base = 16'h0;
  logic             loop_on = 1'b0;
  logic             early = 1'b0;
  int               n_mismatch = 0;
  int               n_tests = 0;
  always #12.5 clk_in = ~clk_in;
  iddl_ctrl #(.RST_HOLD_TICKS(4), .CKE_WAIT_TICKS(4)) i_iddl_ctrl (.clk_in(clk_in),
    .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .ck_out(ck),
    .ck_n_out(ck_n), .cke_out(cke), .mem_reset_n_out(mrst_n), .cs_n_out(cs_n),
    .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .odt_out(odt), .ba_out(ba),
    .addr_out(addr), .dm_out(dm), .dq_in(dq_in), .dq_out(dq_o), .dq_oe_out(dq_oe),
    .dqs_in(dqs_in), .dqs_out(dqs_o), .dqs_oe_out(dqs_oe), .meas_valid_out(meas));
  iddl_mem_model i_iddl_mem_model (.ck_in(ck), .cke_in(cke), .reset_n_in(mrst_n),
    .cmd_in({cs_n, ras_n, cas_n, we_n}), .ba_in(ba), .addr_in(addr), .dq_out(dq_in),
    .dqs_out(dqs_in), .mr_out(mr), .act_cnt_out(act_cnt), .ref_cnt_out(ref_cnt),
    .ref_gap_out(ref_gap), .order_err_out(order_err));
  // no valid flag inside the first pass
  always @(posedge clk_in)
    if (loop_on && meas !== 1'b0 && act_cnt - act_base < 16'd16)
      early <= 1'b1;
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= wd;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  // Bounded wait; kind 0 refreshes, 1 activates, 2 hot mode word, 3 init done
  task automatic wait_for(input int kind, input int n);
    int          i;
    logic [15:0] b;
    b = (kind == 0) ? {8'h0, ref_cnt} : act_cnt;
    for (i = 0; i < 8000; i++)
    begin
      if (kind == 0 && 8'(ref_cnt - b[7:0]) >= n) break;
      if (kind == 1 && act_cnt - b >= 16'(n)) break;
      if (kind == 2 && mr[2][`IDDL_MR2_SRT_BIT] === 1'b1) break;
      if (kind == 3)
      begin
        rd(`IDDL_REG_STATUS);
        if (d[`IDDL_ST_DONE_BIT] === 1'b1) break;
      end
      @(posedge clk_in);
    end
    if (i == 8000)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t: wait %0d ran out", $time, kind);
      close_out();
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd(`IDDL_REG_TIMING); chk(d, 32'h0000271C);
    rd(8'h10); chk(d, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10); chk(d, 32'h0);
    wr(`IDDL_REG_TIMING, 32'h00001234);
    rd(`IDDL_REG_TIMING); chk(d, 32'h00001234);
    wr(`IDDL_REG_TIMING, 32'h0000271C);
    $display("registers test done");
    wait_for(3, 0);
    chk(mr[0], `IDDL_MR0_VAL);
    chk(mr[0][3], 1'b0);
    chk(mr[1], `IDDL_MR1_VAL);
    chk(mr[2], `IDDL_MR2_VAL);
    chk(mr[3], `IDDL_MR3_VAL);
    chk(order_err, 1'b0);
    $display("init test done");
    wait_for(0, 2);
    chk(ref_gap, 32'd156);
    wr(`IDDL_REG_CTRL, 32'h2);
    wait_for(0, 3);
    chk(ref_gap < 16'd156 && ref_gap >= 16'd88, 1'b1);
    $display("refresh test done");
    wr(`IDDL_REG_CTRL, 32'h6);
    wait_for(2, 0);
    chk(mr[2], `IDDL_MR2_VAL | 16'h0080);
    $display("hot reinit test done");
    wr(`IDDL_REG_CTRL, 32'h1);
    act_base <= act_cnt;
    loop_on  <= 1'b1;
    wait_for(1, 17);
    chk(early, 1'b0);
    chk(meas, 1'b1);
    chk(order_err, 1'b0);
    wr(`IDDL_REG_CTRL, 32'h0);
    $display("loop test done");
    close_out();
  end
endmodule
